// ===== usb_ctrl_defs.vh
// Constants for the USB endpoint control and status register block.
//
// Summary of operation
// - 0x10: bit 7 enables the USB function, bits 6..0 hold the device address.
// - 0x11 event flags: bits 7,6,5,3,2,1; reset 0; cleared by writing 0.
// - 0x12 event flags: resume bit 3, port B0 bit 1, timer0 bit 0; write-0 clears.
// - A free-running 50 ms wake-up timer sets its event flag at each expiry.
// - 0x13 bit 7 set by firmware puts the USB interface in suspend.
// - Resume is driven while 0x13 bit 6 is set and the interface is suspended.
// - Endpoint 1 responds only while 0x13 bit 5 is set.
// - With 0x13 bit 3 set, invalid endpoint 0 OUT packets get STALL.
// - Firmware sets 0x13 bit 0; hardware clears it when raising the receive event.
// - 0x14 bit 7 is the last received toggle, bit 6 the receive error.
// - 0x14 bit 5 is direction (1 IN), bit 4 marks a SETUP token.
// - 0x14 low nibble is the byte count of the last accepted endpoint 0 packet.
// - 0x15 bit 7 is set by firmware and cleared when the transmit event rises.
// - A toggle bit in 0x15 picks DATA1 or DATA0 for endpoint 0 IN data.
// - 0x15 bit 5 set makes endpoint 0 answer OUT and IN with STALL.
// - 0x15 bits 3..0 give the endpoint 0 IN byte count; reset 0.
// - 0x16 bit 7 is set by firmware and cleared when the transmit event rises.
// - 0x16 bit 6 picks DATA1 or DATA0 for endpoint 1 IN data.
// - 0x16 bit 5 set makes endpoint 1 answer IN with STALL.
// - 0x16 bits 3..0 give the endpoint 1 IN byte count; reset 0.
// - Endpoint 0 data lands in an 8-byte buffer read at 0x18..0x1F.
// - Writing 1 to an event flag leaves it unchanged; only 0 clears.
// - In a control read, an OUT with toggle 0 or nonzero count is stalled.
// - While receive-ready is clear, an endpoint 0 OUT that is not stalled gets NAK.
// - IN data goes out only with transmit-ready set and stall clear.
`ifndef USB_CTRL_DEFS_VH
`define USB_CTRL_DEFS_VH

`define ADDR_W 7
`define A_ENADDR 7'h10
`define A_FLAGS_A 7'h11
`define A_FLAGS_B 7'h12
`define A_LINK 7'h13
`define A_RXSTAT 7'h14
`define A_TX0 7'h15
`define A_TX1 7'h16
`define A_RXBUF 7'h18
`define RXBUF_DEPTH 8
`define RESET_BYTE 8'h00

`define FLAGS_A_MASK 8'hEE
`define FLAGS_B_MASK 8'h0B
`define LINK_MASK 8'hE9
`define TX_MASK 8'hEF

`define B_EP0_RX 7
`define B_EP0_TX 6
`define B_EP1_TX 5
`define B_BUS_RST 3
`define B_SUSP 2
`define B_WAKE 1
`define B_RESUME 3
`define B_PORTB0 1
`define B_TIMER0 0
`define B_SUSPEND 7
`define B_RSM_OUT 6
`define B_EP1_CFG 5
`define B_CTRL_RD 3
`define B_RX_RDY 0
`define B_TX_RDY 7
`define B_TX_TGL 6
`define B_STALL 5
`define B_ENABLE 7
`define F_COUNT 3:0
`define EP_ZERO 4'h0
`define EP_ONE 4'h1
`define RXBUF_SHIFT 3

`define PID_OUT 2'h0
`define PID_IN 2'h1
`define PID_SETUP 2'h2
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_STALL 2'h2
`define HS_DATA 2'h3

`define WAKE_TIME_MS 50
`define CLK_KHZ 100000
`endif

// ===== usb_endpoint_control_regs.v
// Register file and endpoint handshake control of the USB device engine.
`timescale 1ns/1ns
`include "usb_ctrl_defs.vh"

module usb_endpoint_control_regs #(
   parameter WAKE_CYCLES = `WAKE_TIME_MS * `CLK_KHZ,
   parameter CNT_W = 23
) (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Firmware register port.
   input wire [6:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Tokens from the serial engine.
   input wire tok_valid,
   input wire [1:0] tok_pid,
   input wire [6:0] tok_addr,
   input wire [3:0] tok_ep,
   // Received data packet.
   input wire rx_byte_valid,
   input wire [7:0] rx_byte,
   input wire rx_done,
   input wire rx_toggle,
   input wire rx_error,
   input wire [3:0] rx_count,
   // Host acknowledge of IN data.
   input wire host_ack,
   // Bus and chip events.
   input wire bus_reset_seen,
   input wire suspend_seen,
   input wire resume_seen,
   input wire port_b0_edge,
   input wire timer0_overflow,
   // Handshake request to the serial engine.
   output reg hs_valid,
   output reg [1:0] hs_code,
   output reg tx_ep,
   output reg tx_toggle,
   output reg [3:0] tx_count,
   // Link state.
   output wire usb_active,
   output wire suspend_mode,
   output wire resume_drive,
   output wire ep1_active
);

////////////////////////////////////////////////////////////////////////////////

reg [7:0] enaddr;
reg [7:0] flags_a;
reg [7:0] flags_b;
reg [7:0] link;
// Receive status fields live in separate flops and are packed only for reads.
reg stat_toggle;
reg stat_error;
reg stat_in;
reg stat_setup;
reg [3:0] stat_count;
reg [7:0] tx0;
reg [7:0] tx1;
reg [7:0] rxbuf [0:`RXBUF_DEPTH-1];
reg [CNT_W-1:0] wake_cnt;
reg pend_rx;
reg pend_setup;
reg pend_accept;
reg [3:0] wr_idx;
reg in_wait0;
reg in_wait1;
reg [7:0] next_flags_a;
reg [7:0] next_flags_b;
reg [7:0] next_link;
reg [7:0] next_tx0;
reg [7:0] next_tx1;
reg [7:0] rd_mux;
integer i;

wire wr_hit_en = reg_wr && reg_addr == `A_ENADDR;
wire wr_hit_a = reg_wr && reg_addr == `A_FLAGS_A;
wire wr_hit_b = reg_wr && reg_addr == `A_FLAGS_B;
wire wr_hit_link = reg_wr && reg_addr == `A_LINK;
wire wr_hit_tx0 = reg_wr && reg_addr == `A_TX0;
wire wr_hit_tx1 = reg_wr && reg_addr == `A_TX1;
wire rxbuf_hit = reg_addr[`ADDR_W-1:`RXBUF_SHIFT] == (`A_RXBUF >> `RXBUF_SHIFT);
wire wake_tick = wake_cnt == WAKE_CYCLES - 1;
// A token counts only while the function is enabled, awake and addressed to us.
wire tok_mine = tok_valid && usb_active && !suspend_mode && tok_addr == enaddr[`ADDR_W-1:0];
wire tok_ep0 = tok_mine && tok_ep == `EP_ZERO;
wire tok_ep1 = tok_mine && tok_ep == `EP_ONE && ep1_active;
wire ep0_out_tok = tok_ep0 && tok_pid != `PID_IN;
wire ep0_in_tok = tok_ep0 && tok_pid == `PID_IN;
wire ep1_in_tok = tok_ep1 && tok_pid == `PID_IN;
wire [7:0] rxstat = {stat_toggle, stat_error, stat_in, stat_setup, stat_count};
wire rx_ok = rx_done && pend_rx && !rx_error;
wire out_bad = link[`B_CTRL_RD] && (!rx_toggle || rx_count != 4'h0);
wire rx_take = rx_ok && pend_accept && (pend_setup || !out_bad);
wire ack0 = host_ack && in_wait0;
wire ack1 = host_ack && in_wait1;

assign usb_active = enaddr[`B_ENABLE];
assign suspend_mode = link[`B_SUSPEND];
assign resume_drive = link[`B_RSM_OUT] && link[`B_SUSPEND];
assign ep1_active = link[`B_EP1_CFG];

// Clears only the masked bits written as 0; a one written has no effect.
function [7:0] write_zero_clear;
   input [7:0] cur;
   input hit;
   input [7:0] wdata;
   begin
      if (hit) begin
         write_zero_clear = cur & wdata;
      end else begin
         write_zero_clear = cur;
      end
   end
endfunction

// Plain read-write byte limited to its assigned bits.
function [7:0] write_field;
   input [7:0] cur;
   input hit;
   input [7:0] wdata;
   input [7:0] mask;
   begin
      if (hit) begin
         write_field = wdata & mask;
      end else begin
         write_field = cur;
      end
   end
endfunction

// Answer to an IN token: a stall outranks data, and data needs the ready bit.
function [1:0] in_answer;
   input stall;
   input ready;
   begin
      if (stall) begin
         in_answer = `HS_STALL;
      end else if (ready) begin
         in_answer = `HS_DATA;
      end else begin
         in_answer = `HS_NAK;
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////////////

// Set wins over a firmware clear in the same cycle.
always @* begin
   next_flags_a = write_zero_clear(flags_a, wr_hit_a, reg_wdata);
   next_flags_b = write_zero_clear(flags_b, wr_hit_b, reg_wdata);
   if (rx_take) begin
      next_flags_a[`B_EP0_RX] = 1'b1;
   end
   if (ack0) begin
      next_flags_a[`B_EP0_TX] = 1'b1;
   end
   if (ack1) begin
      next_flags_a[`B_EP1_TX] = 1'b1;
   end
   if (bus_reset_seen) begin
      next_flags_a[`B_BUS_RST] = 1'b1;
   end
   if (suspend_seen) begin
      next_flags_a[`B_SUSP] = 1'b1;
   end
   if (wake_tick) begin
      next_flags_a[`B_WAKE] = 1'b1;
   end
   if (resume_seen) begin
      next_flags_b[`B_RESUME] = 1'b1;
   end
   if (port_b0_edge) begin
      next_flags_b[`B_PORTB0] = 1'b1;
   end
   if (timer0_overflow) begin
      next_flags_b[`B_TIMER0] = 1'b1;
   end
   next_flags_a = next_flags_a & `FLAGS_A_MASK;
   next_flags_b = next_flags_b & `FLAGS_B_MASK;
end

// The hardware clears ready bits; a firmware write in the same cycle wins,
// since firmware is the party that re-arms the endpoint.
always @* begin
   next_link = link;
   next_tx0 = tx0;
   next_tx1 = tx1;
   if (rx_take) begin
      next_link[`B_RX_RDY] = 1'b0;
   end
   if (ack0) begin
      next_tx0[`B_TX_RDY] = 1'b0;
   end
   if (ack1) begin
      next_tx1[`B_TX_RDY] = 1'b0;
   end
   next_link = write_field(next_link, wr_hit_link, reg_wdata, `LINK_MASK);
   next_tx0 = write_field(next_tx0, wr_hit_tx0, reg_wdata, `TX_MASK);
   next_tx1 = write_field(next_tx1, wr_hit_tx1, reg_wdata, `TX_MASK);
end

always @* begin
   rd_mux = `RESET_BYTE;
   case (reg_addr)
      `A_ENADDR: begin
         rd_mux = enaddr;
      end
      `A_FLAGS_A: begin
         rd_mux = flags_a;
      end
      `A_FLAGS_B: begin
         rd_mux = flags_b;
      end
      `A_LINK: begin
         rd_mux = link;
      end
      `A_RXSTAT: begin
         rd_mux = rxstat;
      end
      `A_TX0: begin
         rd_mux = tx0;
      end
      `A_TX1: begin
         rd_mux = tx1;
      end
      default: begin
         if (rxbuf_hit) begin
            rd_mux = rxbuf[reg_addr[2:0]];
         end else begin
            rd_mux = `RESET_BYTE;
         end
      end
   endcase
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk) begin
   if (rst) begin
      enaddr <= `RESET_BYTE;
      flags_a <= `RESET_BYTE;
      flags_b <= `RESET_BYTE;
      link <= `RESET_BYTE;
      tx0 <= `RESET_BYTE;
      tx1 <= `RESET_BYTE;
      reg_rdata <= `RESET_BYTE;
      wake_cnt <= {CNT_W{1'b0}};
   end else begin
      if (wr_hit_en) begin
         enaddr <= reg_wdata;
      end
      flags_a <= next_flags_a;
      flags_b <= next_flags_b;
      link <= next_link;
      tx0 <= next_tx0;
      tx1 <= next_tx1;
      if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
      // The wake timer free-runs from reset; no register restarts it.
      if (wake_tick) begin
         wake_cnt <= {CNT_W{1'b0}};
      end else begin
         wake_cnt <= wake_cnt + 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////

// Packet tracking and handshake choice. Bytes go straight to the buffer,
// so an OUT later stalled by the control-read check may leave bytes behind
// while the status count keeps the last accepted packet but its toggle and error bits follow the stalled one.
always @(posedge clk) begin
   if (rst) begin
      stat_toggle <= 1'b0;
      stat_error <= 1'b0;
      stat_in <= 1'b0;
      stat_setup <= 1'b0;
      stat_count <= 4'h0;
      pend_rx <= 1'b0;
      pend_setup <= 1'b0;
      pend_accept <= 1'b0;
      wr_idx <= 4'h0;
      in_wait0 <= 1'b0;
      in_wait1 <= 1'b0;
      hs_valid <= 1'b0;
      hs_code <= `HS_ACK;
      tx_ep <= 1'b0;
      tx_toggle <= 1'b0;
      tx_count <= 4'h0;
      for (i = 0; i < `RXBUF_DEPTH; i = i + 1) begin
         rxbuf[i] <= `RESET_BYTE;
      end
   end else begin
      hs_valid <= 1'b0;
      if (ack0) begin
         in_wait0 <= 1'b0;
      end
      if (ack1) begin
         in_wait1 <= 1'b0;
      end
      if (tok_valid) begin
         pend_rx <= 1'b0;
         in_wait0 <= 1'b0;
         in_wait1 <= 1'b0;
      end
      if (tok_ep0) begin
         stat_in <= tok_pid == `PID_IN;
         stat_setup <= tok_pid == `PID_SETUP;
      end
      if (ep0_out_tok) begin
         wr_idx <= 4'h0;
         pend_setup <= tok_pid == `PID_SETUP;
         pend_rx <= 1'b1;
         pend_accept <= tok_pid == `PID_SETUP || (!tx0[`B_STALL] && link[`B_RX_RDY]);
      end
      if (ep0_in_tok) begin
         hs_valid <= 1'b1;
         tx_ep <= 1'b0;
         tx_toggle <= tx0[`B_TX_TGL];
         tx_count <= tx0[`F_COUNT];
         hs_code <= in_answer(tx0[`B_STALL], tx0[`B_TX_RDY]);
         in_wait0 <= !tx0[`B_STALL] && tx0[`B_TX_RDY];
      end
      if (ep1_in_tok) begin
         hs_valid <= 1'b1;
         tx_ep <= 1'b1;
         tx_toggle <= tx1[`B_TX_TGL];
         tx_count <= tx1[`F_COUNT];
         hs_code <= in_answer(tx1[`B_STALL], tx1[`B_TX_RDY]);
         in_wait1 <= !tx1[`B_STALL] && tx1[`B_TX_RDY];
      end
      if (rx_byte_valid && pend_rx && pend_accept && wr_idx < `RXBUF_DEPTH) begin
         rxbuf[wr_idx[2:0]] <= rx_byte;
         wr_idx <= wr_idx + 4'h1;
      end
      if (rx_done && pend_rx) begin
         pend_rx <= 1'b0;
         if (pend_accept) begin
            stat_toggle <= rx_toggle;
            stat_error <= rx_error;
         end
      end
      if (rx_ok) begin
         hs_valid <= 1'b1;
         tx_ep <= 1'b0;
         if (pend_setup) begin
            hs_code <= `HS_ACK;
         end else if (tx0[`B_STALL]) begin
            hs_code <= `HS_STALL;
         end else if (out_bad) begin
            hs_code <= `HS_STALL;
         end else if (!pend_accept) begin
            hs_code <= `HS_NAK;
         end else begin
            hs_code <= `HS_ACK;
         end
      end
      if (rx_take) begin
         stat_count <= rx_count;
      end
   end
end

endmodule // usb_endpoint_control_regs

// ===== usb_endpoint_control_regs_sva.sv
// Concurrent checks on the ports of the USB endpoint control block.
`timescale 1ns/1ns
`include "usb_ctrl_defs.vh"
module usb_ctrl_chk (
   // Clock, reset and firmware writes.
   input wire clk,
   input wire rst,
   input wire [6:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   // Tokens and answers.
   input wire tok_valid,
   input wire [1:0] tok_pid,
   input wire [6:0] tok_addr,
   input wire [3:0] tok_ep,
   input wire rx_done,
   input wire hs_valid,
   input wire tx_ep,
   // Link state.
   input wire usb_active,
   input wire suspend_mode,
   input wire resume_drive,
   input wire ep1_active
);
   ////////////////////////////////////////////////////////////
   // Shadow of the device address, so an IN token can be judged as ours.
   reg [6:0] own_addr;
   always @(posedge clk) begin
      if (rst)
         own_addr <= 7'h00;
      else if (reg_wr && reg_addr == `A_ENADDR)
         own_addr <= reg_wdata[6:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence our_in_s;
      tok_valid && tok_pid == `PID_IN && tok_ep == 4'h0 && tok_addr == own_addr && usb_active && !suspend_mode;
   endsequence
   sequence quiet_s;
      !hs_valid;
   endsequence
   in_answer_a: assert property (our_in_s |=> hs_valid) else $error("IN token left unanswered");
   hs_pulse_a: assert property (hs_valid |=> quiet_s) else $error("handshake longer than one cycle");
   hs_cause_a: assert property (hs_valid |-> $past(tok_valid) || $past(rx_done)) else $error("answer without cause");
   susp_quiet_a: assert property (suspend_mode && tok_valid && !rx_done |=> quiet_s) else $error("answer in suspend");
   ep1_quiet_a: assert property (tok_valid && tok_ep == 4'h1 && !ep1_active && !rx_done |=> quiet_s)
      else $error("unconfigured endpoint answered");
   off_quiet_a: assert property (!usb_active && tok_valid && !rx_done |=> quiet_s) else $error("disabled answer");
   resume_out_a: assert property (resume_drive |-> suspend_mode) else $error("resume outside suspend");
   ep1_data_a: assert property (hs_valid && tx_ep |-> $past(ep1_active)) else $error("endpoint 1 not configured");
endmodule // usb_ctrl_chk
bind usb_endpoint_control_regs usb_ctrl_chk i_usb_ctrl_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
   .tok_ep(tok_ep), .rx_done(rx_done), .hs_valid(hs_valid), .tx_ep(tx_ep), .usb_active(usb_active),
   .suspend_mode(suspend_mode), .resume_drive(resume_drive), .ep1_active(ep1_active));

// ===== usb_host_model.sv
// Behavioural low-speed host feeding tokens and data packets to the block.
`timescale 1ns/1ns
`include "usb_ctrl_defs.vh"
module usb_host_model (
   // Clock and answers from the block.
   input wire clk,
   input wire hs_valid,
   input wire [1:0] hs_code,
   // Token fields.
   output reg tok_valid = 1'b0,
   output reg [1:0] tok_pid = 2'h0,
   output reg [6:0] tok_addr = 7'h00,
   output reg [3:0] tok_ep = 4'h0,
   // Data packet and acknowledge.
   output reg rx_byte_valid = 1'b0,
   output reg [7:0] rx_byte = 8'h00,
   output reg rx_done = 1'b0,
   output reg rx_toggle = 1'b0,
   output reg rx_error = 1'b0,
   output reg [3:0] rx_count = 4'h0,
   output reg host_ack = 1'b0
);
   ////////////////////////////////////////////////////////////
   // Set by the bench to send the next data packet with a receive error.
   reg bad_packet = 1'b0;
   // One transaction; gap sets how slowly the host acknowledges data.
   task automatic xfer(input [1:0] pid, input [3:0] ep, input [6:0] adr, input [3:0] n, input tgl,
      input [3:0] gap, output [7:0] res);
      integer i;
      begin
         res = 8'h00;
         @(posedge clk);
         tok_valid <= 1'b1;
         tok_pid <= pid;
         tok_addr <= adr;
         tok_ep <= ep;
         @(posedge clk);
         tok_valid <= 1'b0;
         // Address and endpoint are not held once sampled, so stale values cannot pass for live ones.
         tok_addr <= ~adr;
         tok_ep <= ~ep;
         if (pid != `PID_IN) begin
            for (i = 0; i < n; i = i + 1) begin
               rx_byte_valid <= 1'b1;
               rx_byte <= 8'hA0 + i[7:0];
               @(posedge clk);
            end
            rx_byte_valid <= 1'b0;
            rx_done <= 1'b1;
            rx_toggle <= tgl;
            rx_error <= bad_packet;
            rx_count <= n;
            @(posedge clk);
            rx_done <= 1'b0;
            rx_error <= 1'b0;
            rx_byte <= ~rx_byte;
            rx_count <= ~n;
         end
         for (i = 0; i < 3 && res == 8'h00; i = i + 1) begin
            @(posedge clk);
            if (hs_valid === 1'b1)
               res = {6'h01, hs_code};
         end
         if (res == {6'h01, `HS_DATA}) begin
            repeat (gap) @(posedge clk);
            host_ack <= 1'b1;
            @(posedge clk);
            host_ack <= 1'b0;
         end
      end
   endtask
endmodule // usb_host_model

// ===== tb.sv
// Self-checking testbench of the USB endpoint control block.
`timescale 1ns/1ns
`include "usb_ctrl_defs.vh"
module tb;
   localparam WAKE = 2000;
   localparam [7:0] NONE = 8'h00;
   localparam [7:0] ACK = {6'h01, `HS_ACK};
   localparam [7:0] NAK = {6'h01, `HS_NAK};
   localparam [7:0] STALL = {6'h01, `HS_STALL};
   localparam [7:0] DATA = {6'h01, `HS_DATA};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [4:0] ev = 5'h00;
   logic [7:0] reg_rdata, rx_byte;
   logic tok_valid, rx_byte_valid, rx_done, rx_toggle, rx_error, host_ack, hs_valid, tx_ep, tx_toggle;
   logic [1:0] tok_pid, hs_code;
   logic [6:0] tok_addr;
   logic [3:0] tok_ep, rx_count, tx_count;
   logic usb_active, suspend_mode, resume_drive, ep1_active;
   integer n_fail = 0;
   integer checks_done = 0;
   integer i;
   logic [6:0] ta [0:6] = '{7'h10, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18};
   logic [7:0] te [0:6] = '{8'hFF, 8'hE9, 8'h00, 8'hEF, 8'hEF, 8'h00, 8'h00};
   initial forever #5 clk = ~clk;
   usb_endpoint_control_regs #(.WAKE_CYCLES(WAKE)) i_usb_endpoint_control_regs (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr), .tok_ep(tok_ep),
      .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_done(rx_done), .rx_toggle(rx_toggle),
      .rx_error(rx_error), .rx_count(rx_count), .host_ack(host_ack), .bus_reset_seen(ev[0]),
      .suspend_seen(ev[1]), .resume_seen(ev[2]), .port_b0_edge(ev[3]), .timer0_overflow(ev[4]),
      .hs_valid(hs_valid), .hs_code(hs_code), .tx_ep(tx_ep), .tx_toggle(tx_toggle), .tx_count(tx_count),
      .usb_active(usb_active), .suspend_mode(suspend_mode), .resume_drive(resume_drive), .ep1_active(ep1_active));
   usb_host_model i_usb_host_model (.clk(clk), .hs_valid(hs_valid), .hs_code(hs_code), .tok_valid(tok_valid),
      .tok_pid(tok_pid), .tok_addr(tok_addr), .tok_ep(tok_ep), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
      .rx_done(rx_done), .rx_toggle(rx_toggle), .rx_error(rx_error), .rx_count(rx_count), .host_ack(host_ack));
   ////////////////////////////////////////////////////////////
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rc(input [6:0] a, input [7:0] m, input [7:0] e);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         @(negedge clk);
         chk(reg_rdata & m, e);
      end
   endtask
   // Long packets are also acknowledged slowly by the host.
   task x(input [1:0] p, input [3:0] ep, input [6:0] ad, input [3:0] n, input t, input [7:0] e);
      logic [7:0] r;
      begin
         i_usb_host_model.xfer(p, ep, ad, n, t, n, r);
         chk(r, e);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_fail = n_fail + 1;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
         rc(7'h10 + i[6:0], 8'hFD, 8'h00);
      for (i = 0; i < 7; i = i + 1) begin
         wr(ta[i], 8'hFF);
         rc(ta[i], 8'hFF, te[i]);
      end
      chk({4'h0, usb_active, suspend_mode, resume_drive, ep1_active}, 8'h0F);
      wr(`A_LINK, 8'h41);
      @(negedge clk);
      chk({4'h0, usb_active, suspend_mode, resume_drive, ep1_active}, 8'h08);
      $display("registers done");
      x(`PID_OUT, 4'h0, 7'h7F, 4'h1, 1'b1, STALL);
      x(`PID_IN, 4'h0, 7'h7F, 4'h0, 1'b0, STALL);
      wr(`A_TX0, 8'h00);
      wr(`A_TX1, 8'h00);
      wr(`A_LINK, 8'h00);
      x(`PID_OUT, 4'h0, 7'h7F, 4'h2, 1'b1, NAK);
      wr(`A_LINK, 8'h01);
      x(`PID_OUT, 4'h0, 7'h7F, 4'h3, 1'b1, ACK);
      rc(`A_RXSTAT, 8'hFF, 8'h83);
      rc(`A_LINK, 8'hFF, 8'h00);
      rc(`A_FLAGS_A, 8'hFD, 8'h80);
      rc(7'h1A, 8'hFF, 8'hA2);
      x(`PID_SETUP, 4'h0, 7'h05, 4'h1, 1'b0, NONE);
      wr(`A_ENADDR, 8'h7F);
      rc(`A_ENADDR, 8'hFF, 8'h7F);
      x(`PID_IN, 4'h0, 7'h7F, 4'h0, 1'b0, NONE);
      wr(`A_ENADDR, 8'hFF);
      x(`PID_SETUP, 4'h0, 7'h7F, 4'h8, 1'b0, ACK);
      rc(`A_RXSTAT, 8'hFF, 8'h18);
      rc(7'h1F, 8'hFF, 8'hA7);
      i_usb_host_model.bad_packet = 1'b1;
      x(`PID_SETUP, 4'h0, 7'h7F, 4'h1, 1'b1, NONE);
      i_usb_host_model.bad_packet = 1'b0;
      rc(`A_RXSTAT, 8'hFF, 8'hD8);
      wr(`A_LINK, 8'h09);
      x(`PID_OUT, 4'h0, 7'h7F, 4'h0, 1'b0, STALL);
      x(`PID_OUT, 4'h0, 7'h7F, 4'h0, 1'b1, ACK);
      wr(`A_TX0, 8'hC5);
      x(`PID_IN, 4'h0, 7'h7F, 4'h0, 1'b0, DATA);
      chk({tx_ep, tx_toggle, 2'h0, tx_count}, 8'h45);
      rc(`A_TX0, 8'hFF, 8'h45);
      rc(`A_FLAGS_A, 8'h40, 8'h40);
      rc(`A_RXSTAT, 8'h20, 8'h20);
      x(`PID_IN, 4'h0, 7'h7F, 4'h0, 1'b0, NAK);
      $display("endpoint 0 done");
      wr(`A_LINK, 8'h00);
      wr(`A_TX1, 8'h83);
      x(`PID_IN, 4'h1, 7'h7F, 4'h0, 1'b0, NONE);
      wr(`A_LINK, 8'h20);
      x(`PID_IN, 4'h1, 7'h7F, 4'h3, 1'b0, DATA);
      chk({tx_ep, tx_toggle, 2'h0, tx_count}, 8'h83);
      rc(`A_TX1, 8'hFF, 8'h03);
      rc(`A_FLAGS_A, 8'h20, 8'h20);
      wr(`A_TX1, 8'hE0);
      x(`PID_IN, 4'h1, 7'h7F, 4'h0, 1'b0, STALL);
      wr(`A_LINK, 8'h80);
      x(`PID_IN, 4'h0, 7'h7F, 4'h0, 1'b0, NONE);
      $display("endpoint 1 done");
      wr(`A_FLAGS_A, 8'h00);
      wr(`A_FLAGS_B, 8'h00);
      @(posedge clk);
      ev <= 5'h1F;
      @(posedge clk);
      ev <= 5'h00;
      rc(`A_FLAGS_A, 8'hFD, 8'h0C);
      rc(`A_FLAGS_B, 8'hFF, 8'h0B);
      wr(`A_FLAGS_B, 8'h0A);
      rc(`A_FLAGS_B, 8'hFF, 8'h0A);
      wr(`A_FLAGS_A, 8'hFB);
      rc(`A_FLAGS_A, 8'hFD, 8'h08);
      wr(`A_FLAGS_A, 8'h00);
      repeat (WAKE + 10) @(posedge clk);
      rc(`A_FLAGS_A, 8'h02, 8'h02);
      $display("events done");
      complete_run;
   end
endmodule // tb
